// ==== fpd_assertions.sv ====
// checker on the host-to-flash link and the flash status outputs
// assumes link signals and flash outputs arrive as plain inputs
`timescale 1ns/10ps
`default_nettype none
module fpd_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic so_d,
  input wire logic so_oe,
  input wire logic busy_i,
  input wire logic deep_pd_o,
  input wire logic standby_o,
  input wire logic cmd_valid_o
);
  // ********
  // sck rises within one frame
  // ********
  logic [7:0] rise_reg;
  logic [7:0] rise_next;
  logic       sck_reg;

  // saturates, so a long id read never wraps back to 32
  always_comb begin
    rise_next = rise_reg;
    if (cs_n)
      rise_next = 8'h00;
    else if (sck && !sck_reg && rise_reg != 8'hff)
      rise_next = rise_reg + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rise_reg <= 8'h00;
      sck_reg  <= 1'b0;
    end else begin
      rise_reg <= rise_next;
      sck_reg  <= sck;
    end
  end

  // ********
  // properties
  // ********
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_output_off_idle: assert property (cs_n [*4] |-> !so_oe)
    else $error("output driven while deselected");
  a_standby_state: assert property (
    standby_o |-> !deep_pd_o && !$past(busy_i))
    else $error("standby while busy or powered down");
  a_standby_reached: assert property (
    (cs_n && !busy_i && !deep_pd_o) [*8] |-> standby_o)
    else $error("standby missing while idle");
  a_pd_on_release: assert property (
    $rose(deep_pd_o) |-> cs_n && $past(cs_n, 2))
    else $error("power-down entered while selected");
  a_wake_on_release: assert property (
    $fell(deep_pd_o) |-> cs_n && $past(cs_n, 2))
    else $error("wake taken while selected");
  a_pd_blocked_busy: assert property (
    busy_i [*8] |-> !$rose(deep_pd_o))
    else $error("power-down entered while busy");
  a_pause_quiets_out: assert property (
    !hold_n && !cs_n && !sck |-> !so_oe)
    else $error("output still driven in pause");
  a_id_after_dummies: assert property (
    $rose(so_oe) && $past(hold_n) |-> rise_reg >= 8'h20 && rise_reg <= 8'h21)
    else $error("id output started at wrong bit count");
  a_out_on_falls: assert property (
    so_oe && $past(so_oe) && $changed(so_d) |-> !sck || !$past(sck))
    else $error("output bit changed in clock-high phase");
  a_pd_blocks_cmds: assert property (
    cmd_valid_o |-> !$past(deep_pd_o))
    else $error("command accepted in power-down");
endmodule
`default_nettype wire

// ==== fpd_flash.sv ====
// flash end: power-down, wake, id read and pause on the link
// assumes the host gives init pulses on sck after reset
`timescale 1ns/10ps
`default_nettype none
module fpd_flash #(
  // arbitrary id value
  parameter logic [7:0] ID_BYTE = 8'h5a
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  fpd_link_if.dev         link,
  input  wire logic       busy_i,
  input  wire logic       quad_io_enable_bit_i,
  output logic            deep_pd_o,
  output logic            standby_o,
  output logic            write_latch_clr_o,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_op_o
);

  localparam int CW = fpd_pkg::CNT_W;

  // ************************************************************
  // system clock domain
  // ************************************************************
  logic          cs_s;
  logic          hold_s;
  logic          cs_d_reg;
  logic          pd_reg;
  logic          pd_next;
  logic          stby_reg;
  logic          stby_next;
  logic          wlc_reg;
  logic          wlc_next;
  logic          cv_reg;
  logic          cv_next;
  logic [7:0]    cop_reg;
  logic [7:0]    cop_next;
  logic [CW-1:0] base_reg;
  logic [CW-1:0] base_next;
  logic [6:0]    lrc_reg;
  logic [6:0]    lrc_next;
  logic          lrst_reg;
  logic          lrst_next;
  logic          cs_rise;
  logic [CW-1:0] rel_end;

  // link clock domain
  logic          lrst_k;
  logic          qe_k;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [7:0]    op_reg;
  logic [7:0]    op_next;
  logic          pause_reg;
  logic          pause_next;
  logic [CW-1:0] tag_reg;
  logic [CW-1:0] tag_next;
  logic          so_reg;
  logic          so_next;
  logic          oe_reg;
  logic          oe_next;
  logic [CW-1:0] rel_k;
  logic          tag_ok;
  logic          halt;
  logic          id_on;
  logic          paused;

  // select and pause pins into the system clock
  fpd_sync #(
    .W(2)
  ) u_sync_clk (
    .clk_i(clk_i),
    .d_i  ({link.cs_n, link.hold_n}),
    .q_o  ({cs_s, hold_s})
  );

  // frame state is quiet once select is high, so it is read as is
  assign cs_rise = cs_s & ~cs_d_reg;
  assign rel_end = fpd_pkg::frame_bits(cnt_reg, base_reg);

  // end-of-frame decisions
  always_comb begin
    pd_next   = pd_reg;
    cop_next  = cop_reg;
    base_next = base_reg;
    wlc_next  = 1'b0;
    cv_next   = 1'b0;
    lrc_next  = lrc_reg;
    if (lrc_reg != 7'h00) begin
      lrc_next = lrc_reg - 7'h01;
    end
    lrst_next = (lrc_reg != 7'h00);
    if (cs_rise) begin
      base_next = cnt_reg;
      if (!hold_s && !quad_io_enable_bit_i) begin
        wlc_next = 1'b1;
      end else if (fpd_pkg::on_byte(rel_end)) begin
        if (pd_reg) begin
          if (op_reg == fpd_pkg::OP_WAKE) begin
            pd_next = 1'b0;
          end
        end else if (op_reg == fpd_pkg::OP_POWER_DOWN) begin
          if (!busy_i) begin
            pd_next = 1'b1;
          end
        end else if (op_reg != fpd_pkg::OP_WAKE) begin
          cv_next  = 1'b1;
          cop_next = op_reg;
        end
      end
    end
    // standby needs select high and no busy cycle
    stby_next = cs_s & ~busy_i & ~pd_next;
  end

  // system clock registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cs_d_reg <= 1'b1;
      pd_reg   <= 1'b0;
      stby_reg <= 1'b0;
      wlc_reg  <= 1'b0;
      cv_reg   <= 1'b0;
      cop_reg  <= 8'h00;
      base_reg <= '0;
      lrc_reg  <= 7'(fpd_pkg::LINK_RST_CYC);
      lrst_reg <= 1'b1;
    end else begin
      cs_d_reg <= cs_s;
      pd_reg   <= pd_next;
      stby_reg <= stby_next;
      wlc_reg  <= wlc_next;
      cv_reg   <= cv_next;
      cop_reg  <= cop_next;
      base_reg <= base_next;
      lrc_reg  <= lrc_next;
      lrst_reg <= lrst_next;
    end
  end

  assign deep_pd_o         = pd_reg;
  assign standby_o         = stby_reg;
  assign write_latch_clr_o = wlc_reg;
  assign cmd_valid_o       = cv_reg;
  assign cmd_op_o          = cop_reg;

  // ************************************************************
  // link clock domain
  // ************************************************************
  // link reset and quad enable are long levels, two flops deep
  fpd_sync #(
    .W(2)
  ) u_sync_sck (
    .clk_i(link.sck),
    .d_i  ({lrst_reg, quad_io_enable_bit_i}),
    .q_o  ({lrst_k, qe_k})
  );

  // base only moves between frames, so it is steady here
  assign rel_k  = fpd_pkg::frame_bits(cnt_reg, base_reg);
  // a pause or drive left over from an older frame is stale
  assign tag_ok = (tag_reg == base_reg);
  // a rise is dropped if the pin was low as the low phase ended
  assign halt   = ~link.hold_n & ~qe_k;
  // low phase follows the pin, high phase keeps what the fall saw
  assign paused = link.sck ? (pause_reg & tag_ok)
                           : (~link.hold_n & ~qe_k);
  assign id_on  = (op_reg == fpd_pkg::OP_WAKE) &&
                  (rel_k >= fpd_pkg::ID_LEAD_BITS);

  // rising edge: bit count and opcode capture
  always_comb begin
    cnt_next = cnt_reg;
    op_next  = op_reg;
    if (lrst_k) begin
      cnt_next = '0;
      op_next  = 8'h00;
    end else if (!link.cs_n && !halt) begin
      cnt_next = cnt_reg + 16'h0001;
      if (rel_k < fpd_pkg::OPCODE_BITS) begin
        op_next = {op_reg[6:0], link.si};
      end
    end
  end

  always_ff @(posedge link.sck) begin
    cnt_reg <= cnt_next;
    op_reg  <= op_next;
  end

  // falling edge: pause phase and id output
  always_comb begin
    pause_next = pause_reg & tag_ok;
    tag_next   = base_reg;
    so_next    = so_reg;
    oe_next    = 1'b0;
    if (lrst_k) begin
      pause_next = 1'b0;
      so_next    = 1'b0;
    end else if (!link.cs_n) begin
      // sampled at the start of each low phase; quad mode ignores it
      pause_next = ~link.hold_n & ~qe_k;
      // index wraps every byte, so the id repeats msb first
      so_next    = ID_BYTE[~rel_k[fpd_pkg::IDX_W-1:0]];
      oe_next    = id_on & ~pause_next;
    end
  end

  always_ff @(negedge link.sck) begin
    pause_reg <= pause_next;
    tag_reg   <= tag_next;
    so_reg    <= so_next;
    oe_reg    <= oe_next;
  end

  // drive only inside the frame that set it
  assign link.so_d  = so_reg;
  assign link.so_oe = oe_reg & tag_ok & ~link.cs_n & ~paused;
  // busy cycles never see the pause pin at all

endmodule
`default_nettype wire

// ==== fpd_host.sv ====
// host end: runs one command frame per start pulse, mode 0
// assumes the flash end shares this 10 MHz clock rate
`timescale 1ns/10ps
`default_nettype none
module fpd_host (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  fpd_link_if.host        link,
  input  wire logic       start_i,
  input  wire logic [7:0] op_i,
  input  wire logic [1:0] dummy_i,
  input  wire logic [3:0] rd_len_i,
  input  wire logic       pause_i,
  output logic            ready_o,
  output logic            done_o,
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o
);

  localparam int PW = fpd_pkg::PH_W;
  localparam int BW = fpd_pkg::BITS_W;
  localparam int WW = fpd_pkg::WAIT_W;

  fpd_pkg::fpd_host_state_t st_reg, st_next;
  logic          so_s;
  logic [PW-1:0] ph_reg, ph_next;
  logic [BW-1:0] bits_reg, bits_next;
  logic [BW-1:0] rdb_reg, rdb_next;
  logic [WW-1:0] wait_reg, wait_next;
  logic [7:0]    tx_reg, tx_next;
  logic [7:0]    rx_reg, rx_next;
  logic [7:0]    op_reg, op_next;
  logic          sck_reg, sck_next;
  logic          cs_reg, cs_next;
  logic          hold_reg, hold_next;
  logic          done_reg, done_next;
  logic          rv_reg, rv_next;
  logic [7:0]    rd_reg, rd_next;
  logic          bit_end;
  logic          rd_phase;

  fpd_sync #(
    .W(1)
  ) u_sync_so (
    .clk_i(clk_i),
    .d_i  (link.so),
    .q_o  (so_s)
  );

  assign bit_end = (ph_reg == PW'(2 * fpd_pkg::SCK_HALF - 1));
  // read bits are the last ones of the frame, after opcode and dummies
  assign rd_phase = (rdb_reg != '0) && (bits_reg == rdb_reg);

  // ************************************************************
  // frame sequencer
  // ************************************************************
  always_comb begin
    st_next   = st_reg;
    ph_next   = ph_reg;
    bits_next = bits_reg;
    rdb_next  = rdb_reg;
    wait_next = wait_reg;
    tx_next   = tx_reg;
    rx_next   = rx_reg;
    op_next   = op_reg;
    sck_next  = sck_reg;
    cs_next   = cs_reg;
    hold_next = hold_reg;
    done_next = 1'b0;
    rv_next   = 1'b0;
    rd_next   = rd_reg;
    unique case (st_reg)
      // clock pulses with select high release the far link reset
      fpd_pkg::FPD_INIT, fpd_pkg::FPD_SHIFT: begin
        if (ph_reg == '0) begin
          // pause changes only while the clock is low
          hold_next = ~pause_i;
        end
        // a fresh pause freezes the phase at once, so it can be released
        if (hold_next || st_reg == fpd_pkg::FPD_INIT) begin
          ph_next = ph_reg + PW'(1);
          if (ph_reg == PW'(fpd_pkg::SCK_HALF - 1)) begin
            sck_next = 1'b1;
          end
          if (ph_reg == PW'(fpd_pkg::SCK_HALF) && rd_phase) begin
            rx_next = {rx_reg[6:0], so_s};
          end
          if (bit_end) begin
            ph_next   = '0;
            sck_next  = 1'b0;
            bits_next = bits_reg - BW'(1);
            tx_next   = {tx_reg[6:0], 1'b0};
            if (rd_phase) begin
              rdb_next = rdb_reg - BW'(1);
              if (rdb_reg[2:0] == 3'h1) begin
                rv_next = 1'b1;
                rd_next = rx_reg;
              end
            end
            if (bits_reg == BW'(1)) begin
              st_next = fpd_pkg::FPD_GAP;
              cs_next = 1'b1;
              // wake and power-down need the long settle
              if (st_reg == fpd_pkg::FPD_INIT) begin
                wait_next = WW'(fpd_pkg::LINK_RST_CYC);
              end else if (op_reg == fpd_pkg::OP_POWER_DOWN ||
                           op_reg == fpd_pkg::OP_WAKE) begin
                wait_next = WW'(fpd_pkg::T_RES_CYC);
              end else begin
                wait_next = WW'(fpd_pkg::CS_GAP_CYC);
              end
            end
          end
        end
      end
      fpd_pkg::FPD_IDLE: begin
        if (start_i) begin
          st_next   = fpd_pkg::FPD_SETUP;
          cs_next   = 1'b0;
          op_next   = op_i;
          tx_next   = op_i;
          bits_next = BW'({2'h0, rd_len_i} + {4'h0, dummy_i} + 6'h01)
                      << 3;
          rdb_next  = BW'({rd_len_i, 3'h0});
          wait_next = WW'(fpd_pkg::SETUP_CYC);
        end
      end
      fpd_pkg::FPD_SETUP: begin
        wait_next = wait_reg - WW'(1);
        if (wait_reg == WW'(1)) begin
          st_next = fpd_pkg::FPD_SHIFT;
          ph_next = '0;
        end
      end
      fpd_pkg::FPD_GAP: begin
        wait_next = wait_reg - WW'(1);
        if (wait_reg == WW'(1)) begin
          st_next   = fpd_pkg::FPD_IDLE;
          done_next = 1'b1;
        end
      end
      default: begin
        st_next = fpd_pkg::FPD_IDLE;
        cs_next = 1'b1;
      end
    endcase
  end

  // sequencer registers; link pins come straight from here
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg   <= fpd_pkg::FPD_INIT;
      ph_reg   <= '0;
      bits_reg <= BW'(fpd_pkg::INIT_PULSES);
      rdb_reg  <= '0;
      wait_reg <= '0;
      tx_reg   <= 8'h00;
      rx_reg   <= 8'h00;
      op_reg   <= 8'h00;
      sck_reg  <= 1'b0;
      cs_reg   <= 1'b1;
      hold_reg <= 1'b1;
      done_reg <= 1'b0;
      rv_reg   <= 1'b0;
      rd_reg   <= 8'h00;
    end else begin
      st_reg   <= st_next;
      ph_reg   <= ph_next;
      bits_reg <= bits_next;
      rdb_reg  <= rdb_next;
      wait_reg <= wait_next;
      tx_reg   <= tx_next;
      rx_reg   <= rx_next;
      op_reg   <= op_next;
      sck_reg  <= sck_next;
      cs_reg   <= cs_next;
      hold_reg <= hold_next;
      done_reg <= done_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
    end
  end

  assign link.sck    = sck_reg;
  assign link.cs_n   = cs_reg;
  assign link.si     = tx_reg[7];
  assign link.hold_n = hold_reg;
  assign ready_o     = (st_reg == fpd_pkg::FPD_IDLE);
  assign done_o      = done_reg;
  assign rd_valid_o  = rv_reg;
  assign rd_data_o   = rd_reg;

endmodule
`default_nettype wire

// ==== fpd_link_if.sv ====
// serial link between the flash end and the host end
// assumes the bench instantiates it and hands a modport to each end
`timescale 1ns/10ps
`default_nettype none
interface fpd_link_if;

  // ************************************************************
  // link wires
  // ************************************************************
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic so_d;
  logic so_oe;
  logic so;

  // released line reads high, as with a pull-up
  assign so = so_oe ? so_d : 1'b1;

  modport dev (
    input  sck,
    input  cs_n,
    input  si,
    input  hold_n,
    output so_d,
    output so_oe
  );

  modport host (
    output sck,
    output cs_n,
    output si,
    output hold_n,
    input  so
  );

endinterface
`default_nettype wire

// ==== fpd_pkg.sv ====
// constants, types and helpers shared by both link ends
// assumes a 10 MHz system clock on each end and a mode 0 link
//
// How it works
// - standby while select high and idle
// - opcode b9 then select rise enters power-down
// - power-down ignores all but the wake opcode
// - whole bytes after the opcode byte are ignored
// - partial byte aborts power-down, stays standby
// - reset always clears power-down; standby once select high and not busy
// - power-down opcode ignored while busy
// - opcode ab then select rise wakes device
// - partial byte aborts wake, stays powered down
// - wake plus three dummies shifts id out
// - id byte repeats from bit 7
// - host keeps select high after id read
// - pause never stops a busy cycle
// - quad enable disables the pause function
// - pause starts only in clock-low phase
// - pause tristates output, ignores data and clock
// - pause ends only in clock-low phase
// - select rise during pause aborts, clears latch
// - host waits 20 us after power-down
// - host waits 20 us after plain wake
// - host waits 20 us after id wake
package fpd_pkg;

  // ************************************************************
  // commands and frame layout
  // ************************************************************
  localparam int          CNT_W         = 16;
  localparam int          IDX_W         = 3;
  localparam logic [7:0]  OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0]  OP_WAKE       = 8'hab;
  localparam logic [15:0] OPCODE_BITS   = 16'h0008;
  localparam logic [15:0] ID_LEAD_BITS  = 16'h0020;
  localparam logic [2:0]  BYTE_EDGE     = 3'h0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_RES_NS      = 20000;
  // least wait, so round up to whole cycles
  localparam int T_RES_CYC     =
    (T_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF      = 4;
  localparam int SETUP_CYC     = 4;
  localparam int CS_GAP_CYC    = 8;
  localparam int LINK_RST_CYC  = 64;
  // init pulses must outlast the far link reset plus two sync edges
  localparam int INIT_PULSES   = 12;
  localparam int WAIT_W        = 12;
  localparam int PH_W          = 4;
  localparam int BITS_W        = 8;

  // ************************************************************
  // host sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    FPD_INIT  = 3'h0,
    FPD_IDLE  = 3'h1,
    FPD_SETUP = 3'h3,
    FPD_SHIFT = 3'h2,
    FPD_GAP   = 3'h6
  } fpd_host_state_t;

  // bits clocked in during the current frame
  function automatic logic [CNT_W-1:0] frame_bits(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] base);
    frame_bits = cnt - base;
  endfunction

  // frame closed on a whole byte, opcode complete
  function automatic logic on_byte(input logic [CNT_W-1:0] rel);
    on_byte = (rel >= OPCODE_BITS) && (rel[IDX_W-1:0] == BYTE_EDGE);
  endfunction

endpackage

// ==== fpd_sync.sv ====
// two flip-flop level synchroniser
// assumes the input is a level that stays put for several clocks
`timescale 1ns/10ps
`default_nettype none
module fpd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_reg    <= meta_reg;
  end

  assign q_o = q_reg;

endmodule
`default_nettype wire

// ==== tb_flash_power_down_and_pause_ctrl.sv ====
// bench: host end and flash end on one link, plus a second flash
// end on a bit-banged link for frames the host end never sends
// assumes package, interface, both ends and checker compile first
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_flash_power_down_and_pause_ctrl;
  localparam logic [7:0] ID = 8'h3c; // arbitrary id value
  logic       clk = 1'b0;
  logic       dev_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       start = 1'b0;
  logic [7:0] op = 8'h00;
  logic [1:0] dummy = 2'h0;
  logic [3:0] rd_len = 4'h0;
  logic       pause = 1'b0;
  logic       busy = 1'b0;
  logic       quad2 = 1'b0;
  logic       ready, done, rd_valid, standby, cmd_valid;
  logic       deep_pd, deep_pd2, wlc2;
  logic [7:0] rd_data, cmd_op, last_op;
  logic [7:0] rx_q[$];
  int         fails = 0, checks_done = 0, cmd_seen = 0, wlc_seen = 0;
  fpd_link_if lk ();
  fpd_link_if lk2 ();

  // host clock, then a flash clock of equal rate, offset in phase
  initial forever #50 clk = ~clk;
  initial begin
    #37;
    forever #50 dev_clk = ~dev_clk;
  end

  // ********
  // both ends and the checker
  // ********
  fpd_host i_fpd_host (.clk_i(clk), .rst_n_i(rst_n), .link(lk.host),
    .start_i(start), .op_i(op), .dummy_i(dummy), .rd_len_i(rd_len),
    .pause_i(pause), .ready_o(ready), .done_o(done),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  fpd_flash #(.ID_BYTE(ID)) i_fpd_flash (.clk_i(dev_clk),
    .rst_n_i(rst_n), .link(lk.dev), .busy_i(busy),
    .quad_io_enable_bit_i(1'b0), .deep_pd_o(deep_pd),
    .standby_o(standby), .write_latch_clr_o(),
    .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op));
  fpd_flash #(.ID_BYTE(ID)) i_fpd_flash_2 (.clk_i(dev_clk),
    .rst_n_i(rst_n), .link(lk2.dev), .busy_i(1'b0),
    .quad_io_enable_bit_i(quad2), .deep_pd_o(deep_pd2), .standby_o(),
    .write_latch_clr_o(wlc2), .cmd_valid_o(), .cmd_op_o());
  fpd_assertions i_fpd_assertions (.clk_i(dev_clk), .rst_n_i(rst_n),
    .sck(lk.sck), .cs_n(lk.cs_n), .hold_n(lk.hold_n), .so_d(lk.so_d),
    .so_oe(lk.so_oe), .busy_i(busy), .deep_pd_o(deep_pd),
    .standby_o(standby), .cmd_valid_o(cmd_valid));

  // flash pulses are counted in the flash clock domain
  always @(posedge dev_clk) begin
    if (cmd_valid === 1'b1) begin
      cmd_seen++;
      last_op = cmd_op;
    end
    if (wlc2 === 1'b1)
      wlc_seen++;
  end
  // bytes handed back by the host end
  always @(posedge clk)
    if (rd_valid === 1'b1)
      rx_q.push_back(rd_data);

  // ********
  // drivers
  // ********
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic conclude;
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one host command; waits bounded for ready and done
  task automatic cmd(input logic [7:0] o, input logic [1:0] d,
                     input logic [3:0] l);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    start <= 1'b1;
    op <= o;
    dummy <= d;
    rd_len <= l;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    `CHK("done", 1'b1, done)
    cyc(1);
  endtask

  // one bit-banged pulse; data moves after the fall, pause set high
  task automatic bpulse(input logic b, input logic h);
    lk2.si <= b;
    cyc(4);
    lk2.sck <= 1'b1;
    cyc(2);
    lk2.hold_n <= h;
    cyc(2);
    lk2.sck <= 1'b0;
  endtask

  task automatic bsend(input logic [15:0] v, input int n);
    lk2.cs_n <= 1'b0;
    cyc(4);
    for (int i = 0; i < n; i++)
      bpulse(v[15-i], 1'b1);
  endtask

  task automatic bclose(input logic e);
    cyc(4);
    lk2.cs_n <= 1'b1;
    cyc(12);
    `CHK("deep_pd2", e, deep_pd2)
  endtask

  // ********
  // scenarios
  // ********
  task automatic s_start;
    `CHK("deep_pd", 1'b0, deep_pd)
    `CHK("standby", 1'b1, standby)
    `CHK("so", 1'b1, lk.so)
  endtask

  task automatic s_pd;
    int n;
    cmd(8'hb9, 2'h1, 4'h0);
    `CHK("deep_pd", 1'b1, deep_pd)
    n = cmd_seen;
    cmd(8'h06, 2'h0, 4'h0);
    `CHK("cmds", n, cmd_seen)
    cmd(8'hab, 2'h0, 4'h0);
    `CHK("deep_pd", 1'b0, deep_pd)
  endtask

  // id read out of power-down, paused midway by the host
  task automatic s_id;
    cmd(8'hb9, 2'h0, 4'h0);
    rx_q.delete();
    fork
      cmd(8'hab, 2'h3, 4'h4);
      begin
        cyc(300);
        pause <= 1'b1;
        cyc(40);
        pause <= 1'b0;
      end
    join
    `CHK("id_count", 4, rx_q.size())
    foreach (rx_q[i]) `CHK("id", ID, rx_q[i])
    `CHK("deep_pd", 1'b0, deep_pd)
  endtask

  task automatic s_cmd;
    int n;
    n = cmd_seen;
    cmd(8'h06, 2'h0, 4'h0);
    `CHK("cmds", n + 1, cmd_seen)
    `CHK("cmd_op", 8'h06, last_op)
  endtask

  task automatic s_busy;
    @(posedge dev_clk) busy <= 1'b1;
    cmd(8'hb9, 2'h0, 4'h0);
    `CHK("deep_pd", 1'b0, deep_pd)
    `CHK("standby", 1'b0, standby)
    @(posedge dev_clk) busy <= 1'b0;
    cmd(8'hb9, 2'h0, 4'h0);
    `CHK("deep_pd", 1'b1, deep_pd)
    cmd(8'hab, 2'h0, 4'h0);
  endtask

  task automatic s_partial;
    bsend(16'hb900, 4);
    bclose(1'b0);
    bsend(16'hb9f0, 12);
    bclose(1'b0);
    bsend(16'hb900, 8);
    bclose(1'b1);
    bsend(16'hab00, 4);
    bclose(1'b1);
    bsend(16'hab80, 9);
    bclose(1'b1);
    bsend(16'hab55, 16);
    bclose(1'b0);
  endtask

  // select rises while paused: frame dropped, latch clear pulse
  task automatic s_abort;
    int w;
    w = wlc_seen;
    bsend(16'hb000, 3);
    bpulse(1'b1, 1'b0);
    cyc(8);
    bclose(1'b0);
    lk2.hold_n <= 1'b1;
    `CHK("latch_clear", w + 1, wlc_seen)
    cyc(8);
  endtask

  // three pulses sent in pause: ignored unless quad mode
  task automatic s_pause(input logic q, input logic e);
    @(posedge dev_clk) quad2 <= q;
    bsend(16'hb000, 3);
    bpulse(1'b1, 1'b0);
    bpulse(1'b0, 1'b0);
    bpulse(1'b0, 1'b0);
    bpulse(1'b0, 1'b1);
    bsend(16'h9000, 4);
    bclose(e);
  endtask

  // main sequence; the bit-banged end gets its init pulses first
  initial begin
    lk2.cs_n = 1'b1;
    lk2.sck = 1'b0;
    lk2.si = 1'b0;
    lk2.hold_n = 1'b1;
    cyc(20);
    rst_n <= 1'b1;
    for (int i = 0; i < fpd_pkg::INIT_PULSES; i++)
      bpulse(1'b0, 1'b1);
    cyc(120);
    s_start;
    s_pd;
    s_id;
    s_cmd;
    s_busy;
    s_partial;
    s_abort;
    s_pause(1'b1, 1'b0);
    s_pause(1'b0, 1'b1);
    bsend(16'hab00, 8);
    bclose(1'b0);
    conclude;
  end

  // watchdog, well beyond the four thousand or so cycles the run needs
  initial begin
    cyc(30000);
    fails++;
    conclude;
  end
endmodule
`default_nettype wire
